// File: tb_top.sv
// Purpose: Self-checking bench for tpwm_top
// Assumes: one-cycle APB answer
// Notes:   Straps change only in reset
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clk, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        pin = 1'b0, strap = 1'b0, pready, pslverr, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [2:0]  hreq = 3'h0, lreq = 3'h0, hi, lo, hd, ld;
    int          bad_count = 0, cmp_count = 0;
    tpwm_top i_tpwm_top (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .phase_high_side_input(hi), .phase_low_side_input(lo),
        .pin_config_variant(pin), .mode_strap_high(strap), .high_fet_drive(hd),
        .low_fet_drive(ld));
    tpwm_mcu i_tpwm_mcu (.clk, .hi_req(hreq), .lo_req(lreq), .phase_high_side_input(hi),
        .phase_low_side_input(lo));
    // Free-running clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test
    // One APB transfer, then one idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (int n = 0; n == 0 || (pready !== 1'b1 && n < 20); n++)
            @(posedge clk);
        if (pready !== 1'b1)
        begin
            bad_count++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    // Direct modes: every input pattern
    task automatic t_direct;
        logic [2:0] h, l;
        for (int m = 0; m < 3; m++)
        begin
            hreq <= 3'h0;
            lreq <= 3'h0;
            repeat (3) @(posedge clk);
            apb(1'b1, tpwm_pkg::ADDR_CTRL, 32'(m));
            for (int v = 0; v < 64; v++)
            begin
                h = v[2:0];
                l = v[5:3];
                hreq <= h;
                lreq <= l;
                repeat (4) @(posedge clk);
                chk("high drive", hd, m < 2 ? h & ~l : h & l);
                chk("low drive", ld, l & ~h);
            end
        end
    endtask : t_direct
    // Generated PWM: shapes, duty limits, enables
    task automatic t_gen;
        int t, w, p, r, g, z;
        logic q;
        apb(1'b1, tpwm_pkg::ADDR_PERIOD, 32'h0000_0009);
        apb(1'b1, tpwm_pkg::ADDR_DUTY_A, 32'h0000_000a);
        apb(1'b1, tpwm_pkg::ADDR_DUTY_C, 32'h0000_0005);
        apb(1'b1, tpwm_pkg::ADDR_DEAD, 32'h0000_0001);
        for (int s = 3; s >= 0; s--)
        begin
            hreq <= 3'h0;
            lreq <= 3'h0;
            apb(1'b1, tpwm_pkg::ADDR_CTRL, 32'(s == 3 ? 87 : 19 + 4 * s));
            hreq <= 3'h7;
            r = 0;
            w = 0;
            p = 0;
            g = 0;
            z = 0;
            q = 1'b1;
            for (t = 0; t < 300 && r < 4; t++)
            begin
                // Sync reference every 12 cycles on phase B low pin
                if (s == 3)
                    lreq <= {1'b0, t % 12 < 6, 1'b0};
                @(posedge clk);
                if (hd[2] === 1'b1 && q === 1'b0)
                begin
                    w = t - p;
                    p = t;
                    g = z;
                    z = 0;
                    r++;
                end
                if ((hd[2] | ld[2]) === 1'b0)
                    z++;
                q = hd[2];
            end
            chk("pwm period", w, s == 3 ? 12 : s == 0 ? 18 : 10);
            chk("dead gap", g, 4);
        end
        chk("high full and zero", hd[1:0], 2'h1);
        chk("low complement", ld[1:0], 2'h2);
        hreq <= 3'h0;
        apb(1'b1, tpwm_pkg::ADDR_CTRL, 32'h0000_0003);
        repeat (20) @(posedge clk);
        chk("high disabled", hd, 3'h0);
        apb(1'b1, tpwm_pkg::ADDR_SWITCH, 32'h0000_0007);
        repeat (20) @(posedge clk);
        chk("low disabled", ld, 3'h0);
    endtask : t_gen
    // Pin variant: strap latched on the first edge after reset release
    task automatic t_strap;
        for (int s = 0; s < 2; s++)
        begin
            rst <= 1'b1;
            pin <= 1'b1;
            strap <= s[0];
            hreq <= 3'h3;
            lreq <= 3'h5;
            repeat (3) @(posedge clk);
            rst <= 1'b0;
            repeat (4) @(posedge clk);
            apb(1'b1, tpwm_pkg::ADDR_CTRL, 32'h0000_0003);
            apb(1'b0, tpwm_pkg::ADDR_STATUS, 32'h0000_0000);
            chk("strap mode", rd[15:13], s ? 3'h6 : 3'h4);
            chk("strap drive", hd, s ? 3'h1 : 3'h2);
        end
    endtask : t_strap
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, tpwm_pkg::ADDR_PERIOD, 32'h0000_0000);
        chk("period reset", rd, 32'(tpwm_pkg::PERIOD_RST));
        apb(1'b0, tpwm_pkg::ADDR_SWITCH, 32'h0000_0000);
        chk("switch reset", rd, 32'h0000_003f);
        apb(1'b0, 8'h20, 32'h0000_0000);
        chk("unmapped error", err, 1'b1);
        t_direct();
        t_gen();
        t_strap();
        finish_test();
    end
endmodule : tb_top
`default_nettype wire

// File: tpwm_counter.sv
// Purpose: Shared reference counter for the generated PWM.
// Assumes: enable low parks the counter at its start value.
// Notes:   External period mode uses the full counter range as ceiling.
`default_nettype none
`timescale 1ns/10ps

module tpwm_counter
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [1:0]  shape,
    input  wire logic [11:0] period,
    input  wire logic        enable,
    input  wire logic        ext_period,
    input  wire logic        restart,
    output logic      [11:0] count,
    output logic             counting_up
);

    typedef struct packed {
        logic [11:0]          cnt;
        tpwm_pkg::tpwm_dir_t  dir;
    } tpwm_cnt_state_t;

    tpwm_cnt_state_t cur_ff;
    tpwm_cnt_state_t nxt_cur;
    logic [11:0]     limit;

    // Next counter value per shape
    always_comb
    begin
        nxt_cur = cur_ff;
        limit = ext_period ? tpwm_pkg::CNT_MAX : period;
        if (!enable || restart)
        begin
            nxt_cur.cnt = (shape == tpwm_pkg::SHAPE_UP) ? 12'h000 : limit;
            nxt_cur.dir = (shape == tpwm_pkg::SHAPE_UP) ? tpwm_pkg::dir_up : tpwm_pkg::dir_down;
        end
        else
        begin
            case (shape)
                tpwm_pkg::SHAPE_UP:
                begin
                    nxt_cur.dir = tpwm_pkg::dir_up;
                    nxt_cur.cnt = (cur_ff.cnt >= limit) ? 12'h000 : cur_ff.cnt + 12'h001;
                end
                tpwm_pkg::SHAPE_DOWN:
                begin
                    nxt_cur.dir = tpwm_pkg::dir_down;
                    nxt_cur.cnt = (cur_ff.cnt == 12'h000) ? limit : cur_ff.cnt - 12'h001;
                end
                default:
                begin
                    case (cur_ff.dir)
                        tpwm_pkg::dir_down:
                        begin
                            if (cur_ff.cnt == 12'h000)
                            begin
                                nxt_cur.dir = tpwm_pkg::dir_up;
                                nxt_cur.cnt = (limit == 12'h000) ? 12'h000 : 12'h001;
                            end
                            else
                            begin
                                nxt_cur.cnt = cur_ff.cnt - 12'h001;
                            end
                        end
                        tpwm_pkg::dir_up:
                        begin
                            if (cur_ff.cnt >= limit)
                            begin
                                nxt_cur.dir = tpwm_pkg::dir_down;
                                nxt_cur.cnt = (limit == 12'h000) ? 12'h000 : limit - 12'h001;
                            end
                            else
                            begin
                                nxt_cur.cnt = cur_ff.cnt + 12'h001;
                            end
                        end
                        default:
                        begin
                            nxt_cur.dir = tpwm_pkg::dir_down;
                        end
                    endcase
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cur_ff <= {12'h000, tpwm_pkg::dir_down};
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    assign count       = cur_ff.cnt;
    assign counting_up = (cur_ff.dir == tpwm_pkg::dir_up);

endmodule : tpwm_counter

`default_nettype wire

// File: tpwm_dead.sv
// Purpose: Dead-time insertion for one phase's complementary FET drives.
// Assumes: dead count is in system clock cycles.
// Notes:   Every demand edge turns both FETs off for at least one cycle.
`default_nettype none
`timescale 1ns/10ps

module tpwm_dead
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       pwm_hi,
    input  wire logic       hs_en,
    input  wire logic       ls_en,
    input  wire logic [7:0] dead,
    output logic            hs_drive,
    output logic            ls_drive
);

    typedef struct packed {
        logic       last;
        logic [7:0] cnt;
        logic       hs;
        logic       ls;
    } tpwm_dead_state_t;

    tpwm_dead_state_t cur_ff;
    tpwm_dead_state_t nxt_cur;

    // Gap after each edge of the demand
    always_comb
    begin
        nxt_cur = cur_ff;
        if (pwm_hi != cur_ff.last)
        begin
            nxt_cur.last = pwm_hi;
            nxt_cur.cnt  = dead;
            nxt_cur.hs   = 1'b0;
            nxt_cur.ls   = 1'b0;
        end
        else if (cur_ff.cnt != 8'h00)
        begin
            nxt_cur.cnt = cur_ff.cnt - 8'h01;
            nxt_cur.hs  = 1'b0;
            nxt_cur.ls  = 1'b0;
        end
        else
        begin
            nxt_cur.hs = pwm_hi & hs_en;
            nxt_cur.ls = ~pwm_hi & ls_en;
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cur_ff <= '0;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    assign hs_drive = cur_ff.hs;
    assign ls_drive = cur_ff.ls;

endmodule : tpwm_dead

`default_nettype wire

// File: tpwm_mcu.sv
// Purpose: Controller model on phase inputs
// Assumes: requests change after an edge
// Notes:   Pins follow one cycle later
`timescale 1ns/10ps
`default_nettype none
module tpwm_mcu
(
    input  wire logic       clk,
    input  wire logic [2:0] hi_req,
    input  wire logic [2:0] lo_req,
    output logic      [2:0] phase_high_side_input,
    output logic      [2:0] phase_low_side_input
);
    always_ff @(posedge clk)
    begin
        phase_high_side_input <= hi_req;
        phase_low_side_input  <= lo_req;
    end
endmodule : tpwm_mcu
`default_nettype wire

// File: tpwm_pkg.sv
// Purpose: Shared constants and types for the three-phase PWM control block.
// Assumes: APB register map with 32-bit aligned words, 12-bit counter.
// Notes:   Every offset, field position and reset value is named here once.
`default_nettype none

package tpwm_pkg;

    // Register byte offsets
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_PERIOD    = 8'h04;
    localparam logic [7:0]  ADDR_DUTY_A    = 8'h08;
    localparam logic [7:0]  ADDR_DUTY_B    = 8'h0c;
    localparam logic [7:0]  ADDR_DUTY_C    = 8'h10;
    localparam logic [7:0]  ADDR_DEAD      = 8'h14;
    localparam logic [7:0]  ADDR_SWITCH    = 8'h18;
    localparam logic [7:0]  ADDR_STATUS    = 8'h1c;

    // Control register field positions
    localparam int          CTRL_MODE_LSB  = 0;
    localparam int          CTRL_SHAPE_LSB = 2;
    localparam int          CTRL_EN_BIT    = 4;
    localparam int          CTRL_SYNC_LSB  = 5;

    // Switch enable register field positions
    localparam int          SW_HS_LSB      = 0;
    localparam int          SW_LS_LSB      = 3;

    // Status register field positions
    localparam int          ST_COUNT_LSB   = 0;
    localparam int          ST_DIR_BIT     = 12;
    localparam int          ST_MODE_LSB    = 13;
    localparam int          ST_STRAP_BIT   = 15;
    localparam int          ST_HS_LSB      = 16;
    localparam int          ST_LS_LSB      = 19;

    // Control mode encodings
    localparam logic [1:0]  MODE_6X_A      = 2'h0;
    localparam logic [1:0]  MODE_6X_B      = 2'h1;
    localparam logic [1:0]  MODE_3X        = 2'h2;
    localparam logic [1:0]  MODE_GEN       = 2'h3;

    // Counter shape encodings
    localparam logic [1:0]  SHAPE_UPDOWN   = 2'h0;
    localparam logic [1:0]  SHAPE_UP       = 2'h1;
    localparam logic [1:0]  SHAPE_DOWN     = 2'h2;

    // Sync method: period taken from the sync reference edges
    localparam logic [2:0]  SYNC_EXT_PRD   = 3'h2;

    // Counter width and ceiling
    localparam int          CNT_W          = 12;
    localparam logic [11:0] CNT_MAX        = 12'hfff;
    localparam int          DEAD_W         = 8;

    // Reset values
    localparam logic [1:0]  MODE_RST       = 2'h0;
    localparam logic [1:0]  SHAPE_RST      = 2'h0;
    localparam logic [2:0]  SYNC_RST       = 3'h0;
    localparam logic [11:0] PERIOD_RST     = 12'h03e8;
    localparam logic [11:0] DUTY_RST       = 12'h0000;
    localparam logic [7:0]  DEAD_RST       = 8'h0a;
    localparam logic [2:0]  SW_EN_RST      = 3'h7;

    // Reference counter direction
    typedef enum logic [1:0]
    {
        dir_up   = 2'b01,
        dir_down = 2'b10
    } tpwm_dir_t;

endpackage : tpwm_pkg

`default_nettype wire

// File: tpwm_top.sv
// Purpose: Three-phase half-bridge control: 6x, 3x and PWM generation modes.
// Assumes: phase inputs synchronous to clk; APB slave with no wait states.
// Notes:   Hi-Z is both FETs off; high is high FET on; low is low FET on.
`default_nettype none
`timescale 1ns/10ps

module tpwm_top
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [2:0]  phase_high_side_input,
    input  wire logic [2:0]  phase_low_side_input,
    input  wire logic        pin_config_variant,
    input  wire logic        mode_strap_high,
    output logic      [2:0]  high_fet_drive,
    output logic      [2:0]  low_fet_drive
);

    typedef struct packed {
        logic [1:0]       mode;
        logic [1:0]       shape;
        logic             gen_en;
        logic [2:0]       sync_sel;
        logic [11:0]      period;
        logic [2:0][11:0] duty;
        logic [7:0]       dead;
        logic [2:0]       hs_sw_en;
        logic [2:0]       ls_sw_en;
        logic             strap_taken;
        logic             pin_var;
        logic [1:0]       strap_mode;
        logic             sync_prev;
        logic             sync_pulse;
        logic [2:0]       pwm_hi;
        logic [2:0]       hs_out;
        logic [2:0]       ls_out;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
    } tpwm_top_state_t;

    tpwm_top_state_t cur_ff;
    tpwm_top_state_t nxt_cur;

    logic [11:0] ref_count;
    logic        ref_up;
    logic [2:0]  dt_hs;
    logic [2:0]  dt_ls;
    logic [1:0]  eff_mode;
    logic        gen_active;
    logic        ext_prd;
    logic        wr_take;

    // Known register address
    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == tpwm_pkg::ADDR_CTRL)   || (a == tpwm_pkg::ADDR_PERIOD)  ||
                     (a == tpwm_pkg::ADDR_DUTY_A) || (a == tpwm_pkg::ADDR_DUTY_B)  ||
                     (a == tpwm_pkg::ADDR_DUTY_C) || (a == tpwm_pkg::ADDR_DEAD)    ||
                     (a == tpwm_pkg::ADDR_SWITCH) || (a == tpwm_pkg::ADDR_STATUS);
    endfunction : addr_known

    // 6x decode: returns {high fet, low fet}
    function automatic logic [1:0] decode_6x(input logic inh, input logic inl);
        decode_6x = {inh & ~inl, inl & ~inh};
    endfunction : decode_6x

    // 3x decode: returns {high fet, low fet}
    function automatic logic [1:0] decode_3x(input logic inh, input logic inl);
        decode_3x = inl ? {inh, ~inh} : 2'b00;
    endfunction : decode_3x

    // Effective mode from strap or register
    // pin variant uses latched strap
    assign eff_mode   = cur_ff.pin_var ? cur_ff.strap_mode : cur_ff.mode;
    assign gen_active = (eff_mode == tpwm_pkg::MODE_GEN);
    assign ext_prd    = (cur_ff.sync_sel == tpwm_pkg::SYNC_EXT_PRD);
    assign wr_take    = psel & penable & cur_ff.pready & pwrite;

    // Shared reference counter
    // one counter for all phases
    tpwm_counter u_counter
    (
        .clk         (clk),
        .rst         (rst),
        .shape       (cur_ff.shape),
        .period      (cur_ff.period),
        .enable      (gen_active),
        .ext_period  (ext_prd),
        .restart     (cur_ff.sync_pulse),
        .count       (ref_count),
        .counting_up (ref_up)
    );

    // Dead-time stage per phase
    for (genvar g = 0; g < 3; g++)
    begin : g_dead
        tpwm_dead u_dead
        (
            .clk      (clk),
            .rst      (rst),
            .pwm_hi   (cur_ff.pwm_hi[g]),
            .hs_en    (cur_ff.hs_sw_en[g]),
            .ls_en    (cur_ff.ls_sw_en[g]),
            .dead     (cur_ff.dead),
            .hs_drive (dt_hs[g]),
            .ls_drive (dt_ls[g])
        );
    end

    // Next state: bus, strap, sync, compare, output mux
    always_comb
    begin
        nxt_cur = cur_ff;

        // Strap taken once after reset release
        if (!cur_ff.strap_taken)
        begin
            nxt_cur.strap_taken = 1'b1;
            nxt_cur.pin_var     = pin_config_variant;
            nxt_cur.strap_mode  = mode_strap_high ? tpwm_pkg::MODE_3X : tpwm_pkg::MODE_6X_A;
        end

        // sync edge from phase B low pin
        nxt_cur.sync_prev  = phase_low_side_input[1];
        nxt_cur.sync_pulse = gen_active & ext_prd & phase_low_side_input[1] & ~cur_ff.sync_prev;

        // Duty compare per phase
        for (int i = 0; i < 3; i++)
        begin
            nxt_cur.pwm_hi[i] = cur_ff.gen_en & gen_active & (cur_ff.duty[i] > ref_count);
        end

        // Phase output state per mode
        for (int i = 0; i < 3; i++)
        begin
            case (eff_mode)
                tpwm_pkg::MODE_GEN:
                begin
                    nxt_cur.hs_out[i] = dt_hs[i];
                    nxt_cur.ls_out[i] = dt_ls[i];
                end
                tpwm_pkg::MODE_3X:
                begin
                    {nxt_cur.hs_out[i], nxt_cur.ls_out[i]} =
                        decode_3x(phase_high_side_input[i], phase_low_side_input[i]);
                end
                default:
                begin
                    {nxt_cur.hs_out[i], nxt_cur.ls_out[i]} =
                        decode_6x(phase_high_side_input[i], phase_low_side_input[i]);
                end
            endcase
        end

        // APB setup cycle: prepare answer
        nxt_cur.pready  = psel & ~penable;
        nxt_cur.pslverr = psel & ~penable & ~addr_known(paddr);
        nxt_cur.prdata  = 32'h0000_0000;
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                tpwm_pkg::ADDR_CTRL:
                begin
                    nxt_cur.prdata[tpwm_pkg::CTRL_MODE_LSB +: 2]  = cur_ff.mode;
                    nxt_cur.prdata[tpwm_pkg::CTRL_SHAPE_LSB +: 2] = cur_ff.shape;
                    nxt_cur.prdata[tpwm_pkg::CTRL_EN_BIT]         = cur_ff.gen_en;
                    nxt_cur.prdata[tpwm_pkg::CTRL_SYNC_LSB +: 3]  = cur_ff.sync_sel;
                end
                tpwm_pkg::ADDR_PERIOD:
                begin
                    nxt_cur.prdata[11:0] = cur_ff.period;
                end
                tpwm_pkg::ADDR_DUTY_A:
                begin
                    nxt_cur.prdata[11:0] = cur_ff.duty[0];
                end
                tpwm_pkg::ADDR_DUTY_B:
                begin
                    nxt_cur.prdata[11:0] = cur_ff.duty[1];
                end
                tpwm_pkg::ADDR_DUTY_C:
                begin
                    nxt_cur.prdata[11:0] = cur_ff.duty[2];
                end
                tpwm_pkg::ADDR_DEAD:
                begin
                    nxt_cur.prdata[7:0] = cur_ff.dead;
                end
                tpwm_pkg::ADDR_SWITCH:
                begin
                    nxt_cur.prdata[tpwm_pkg::SW_HS_LSB +: 3] = cur_ff.hs_sw_en;
                    nxt_cur.prdata[tpwm_pkg::SW_LS_LSB +: 3] = cur_ff.ls_sw_en;
                end
                tpwm_pkg::ADDR_STATUS:
                begin
                    nxt_cur.prdata[tpwm_pkg::ST_COUNT_LSB +: 12] = ref_count;
                    nxt_cur.prdata[tpwm_pkg::ST_DIR_BIT]         = ref_up;
                    nxt_cur.prdata[tpwm_pkg::ST_MODE_LSB +: 2]   = eff_mode;
                    nxt_cur.prdata[tpwm_pkg::ST_STRAP_BIT]       = cur_ff.pin_var;
                    nxt_cur.prdata[tpwm_pkg::ST_HS_LSB +: 3]     = cur_ff.hs_out;
                    nxt_cur.prdata[tpwm_pkg::ST_LS_LSB +: 3]     = cur_ff.ls_out;
                end
                default:
                begin
                    nxt_cur.prdata = 32'h0000_0000;
                end
            endcase
        end

        // APB access edge: write takes effect
        if (wr_take)
        begin
            case (paddr)
                tpwm_pkg::ADDR_CTRL:
                begin
                    nxt_cur.mode     = pwdata[tpwm_pkg::CTRL_MODE_LSB +: 2];
                    nxt_cur.shape    = pwdata[tpwm_pkg::CTRL_SHAPE_LSB +: 2];
                    nxt_cur.gen_en   = pwdata[tpwm_pkg::CTRL_EN_BIT];
                    nxt_cur.sync_sel = pwdata[tpwm_pkg::CTRL_SYNC_LSB +: 3];
                end
                tpwm_pkg::ADDR_PERIOD:
                begin
                    nxt_cur.period = pwdata[11:0];
                end
                tpwm_pkg::ADDR_DUTY_A:
                begin
                    nxt_cur.duty[0] = pwdata[11:0];
                end
                tpwm_pkg::ADDR_DUTY_B:
                begin
                    nxt_cur.duty[1] = pwdata[11:0];
                end
                tpwm_pkg::ADDR_DUTY_C:
                begin
                    nxt_cur.duty[2] = pwdata[11:0];
                end
                tpwm_pkg::ADDR_DEAD:
                begin
                    nxt_cur.dead = pwdata[7:0];
                end
                tpwm_pkg::ADDR_SWITCH:
                begin
                    nxt_cur.hs_sw_en = pwdata[tpwm_pkg::SW_HS_LSB +: 3];
                    nxt_cur.ls_sw_en = pwdata[tpwm_pkg::SW_LS_LSB +: 3];
                end
                default:
                begin
                    nxt_cur.dead = cur_ff.dead;
                end
            endcase
        end
    end

    // State register with reset values
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cur_ff          <= '0;
            cur_ff.mode     <= tpwm_pkg::MODE_RST;
            cur_ff.shape    <= tpwm_pkg::SHAPE_RST;
            cur_ff.sync_sel <= tpwm_pkg::SYNC_RST;
            cur_ff.period   <= tpwm_pkg::PERIOD_RST;
            cur_ff.duty     <= {3{tpwm_pkg::DUTY_RST}};
            cur_ff.dead     <= tpwm_pkg::DEAD_RST;
            cur_ff.hs_sw_en <= tpwm_pkg::SW_EN_RST;
            cur_ff.ls_sw_en <= tpwm_pkg::SW_EN_RST;
        end
        else
        begin
            cur_ff <= nxt_cur;
        end
    end

    // Outputs straight from flip-flops
    assign prdata         = cur_ff.prdata;
    assign pready         = cur_ff.pready;
    assign pslverr        = cur_ff.pslverr;
    assign high_fet_drive = cur_ff.hs_out;
    assign low_fet_drive  = cur_ff.ls_out;

endmodule : tpwm_top

`default_nettype wire

// File: tpwm_top_assertions.sv
// Purpose: Port checks for tpwm_top
// Assumes: straps move only in reset
// Notes:   Bound into every tpwm_top
`timescale 1ns/10ps
`default_nettype none
module tpwm_chk
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [2:0]  phase_high_side_input,
    input wire logic [2:0]  phase_low_side_input,
    input wire logic        pin_config_variant,
    input wire logic        mode_strap_high,
    input wire logic [2:0]  high_fet_drive,
    input wire logic [2:0]  low_fet_drive
);
    logic [1:0] age_ff;
    logic [2:0] h;
    logic [2:0] l;
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    sequence setup_s; psel && !penable; endsequence
    sequence strap_s(b); age_ff == 2'h3 && pin_config_variant && mode_strap_high == b;
    endsequence
    // Short aliases for the phase inputs
    assign h = phase_high_side_input;
    assign l = phase_low_side_input;
    // Edges since reset release, saturating
    always_ff @(posedge clk or posedge rst)
        if (rst)
            age_ff <= 2'h0;
        else if (age_ff != 2'h3)
            age_ff <= age_ff + 2'h1;
    AST_NO_SHOOT:
        assert property (!(|(high_fet_drive & low_fet_drive))) else $error("shoot-through");
    AST_READY_NEXT:
        assert property (setup_s |=> pready) else $error("no ready after setup");
    AST_READY_ONE:
        assert property (pready |=> !pready) else $error("ready too long");
    AST_ERR_READY:
        assert property (pslverr |-> pready) else $error("error without ready");
    AST_UNMAP:
        assert property (setup_s |=> pslverr ==
            ($past(paddr) > 8'h1c || |($past(paddr) & 8'h03)))
            else $error("error flag wrong");
    AST_6X_MAP:
        assert property (strap_s(1'b0) |=> high_fet_drive == ($past(h) & ~$past(l))
            && low_fet_drive == ($past(l) & ~$past(h))) else $error("6x map wrong");
    AST_3X_HIZ:
        assert property (strap_s(1'b1) ##0 !l[1] |=> !high_fet_drive[1] && !low_fet_drive[1])
            else $error("3x hi-z wrong");
    AST_3X_MAP:
        assert property (strap_s(1'b1) |=> high_fet_drive == ($past(h) & $past(l))
            && low_fet_drive == ($past(l) & ~$past(h))) else $error("3x map wrong");
endmodule : tpwm_chk
bind tpwm_top tpwm_chk i_tpwm_chk (.clk, .rst, .psel, .penable, .paddr, .pready, .pslverr,
    .phase_high_side_input, .phase_low_side_input, .pin_config_variant, .mode_strap_high,
    .high_fet_drive, .low_fet_drive);
`default_nettype wire
